// ===== hw/mis_core.v
// execution unit for add, and, clear, complement, adjust, inc/dec, branches
// Behaviour
// [RULE_01] add with carry into accumulator or memory
// [RULE_02] add memory or immediate into accumulator
// [RULE_03] add accumulator into memory, no carry
// [RULE_04] and into accumulator, zero flag only
// [RULE_05] and into memory, zero flag only
// [RULE_06] call pushes pc plus one, jumps
// [RULE_07] memory clear writes zero, flags kept
// [RULE_08] bit clear touches selected bit only
// [RULE_09] watchdog clear zeroes counter, both flags
// [RULE_10] both preclears together clear watchdog
// [RULE_11] single preclear only sets indicator
// [RULE_12] complement memory in place, zero flag
// [RULE_13] complement into accumulator, memory unchanged
// [RULE_14] low nibble adjust above nine adds six
// [RULE_15] high nibble adjust with carry set
// [RULE_16] adjust result goes to memory, carry only
// [RULE_17] decrement into memory or accumulator
// [RULE_18] increment into memory or accumulator
// [RULE_19] halt advances pc, stops clock
// [RULE_20] halt clears watchdog, sets powerdown flag
// [RULE_21] direct jump loads address, no push
// [RULE_22] pc low byte write adds one cycle
// [RULE_23] overflow signed, half carry from bit three
// [RULE_24] zero flag tracks written result
`include "mis_defines.vh"

module mis_core #(
    parameter PC_W = 11,
    parameter STACK_DEPTH = 6,
    parameter WDT_W = 8,
    parameter PRE_W = 8
) (
    input wire clk,
    input wire srst,
    input wire op_valid,
    input wire [4:0] op,
    input wire [7:0] mem_rdata,
    input wire [7:0] imm_data,
    input wire use_imm,
    input wire [2:0] bit_sel,
    input wire [PC_W-1:0] target_addr,
    input wire mem_is_pc_low_byte,
    input wire wdt_tick,
    output wire op_ready,
    output reg mem_we,
    output reg [7:0] mem_wdata,
    output reg [7:0] acc_reg,
    output reg [PC_W-1:0] pc_reg,
    output reg carry_flag,
    output reg half_carry_flag,
    output reg zero_flag,
    output reg signed_wrap_flag,
    output reg powerdown_flag,
    output reg timeout_flag,
    output reg preclear_first_seen,
    output reg preclear_second_seen,
    output reg halted,
    output reg [WDT_W-1:0] watchdog_counter,
    output reg [PRE_W-1:0] wdt_prescaler,
    output wire [PC_W-1:0] stack_top,
    output wire [2:0] stack_level
);
    // ----------------------------------------
    // sequencing states
    // ----------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_BUSY = 2'b01;
    localparam ST_HALT = 2'b10;

    reg [1:0] state_reg;
    reg [3:0] wait_reg;
    reg [3:0] wait_next;

    // operand selection; the immediate only exists for the two
    // accumulator forms, so a stray use_imm must not leak into the
    // carry and memory-destination adds
    wire imm_op = (op == `MIS_OP_ADD_A) || (op == `MIS_OP_AND_A);
    wire [7:0] opnd = (use_imm && imm_op) ? imm_data : mem_rdata;
    wire with_c = (op == `MIS_OP_ADC_A) || (op == `MIS_OP_ADC_M);
    wire [8:0] sum9 = {1'b0, acc_reg} + {1'b0, opnd} +
                      {8'h00, with_c & carry_flag}; // [RULE_01]
    wire [4:0] low5 = {1'b0, acc_reg[3:0]} + {1'b0, opnd[3:0]} +
                      {4'h0, with_c & carry_flag};
    // signed wrap: same input signs, different result sign
    wire ovf = (acc_reg[7] == opnd[7]) &&
               (sum9[7] != acc_reg[7]); // [RULE_23]

    // decimal adjust of the accumulator
    // the low fix leans on the half carry left behind by the last add
    wire lo_fix = ({1'b0, acc_reg[3:0]} > `MIS_BCD_LIMIT) ||
                  half_carry_flag; // [RULE_14]
    wire [4:0] lo_sum = {1'b0, acc_reg[3:0]} + `MIS_BCD_ADD;
    wire [3:0] lo_res = lo_fix ? lo_sum[3:0] : acc_reg[3:0];
    wire low_nibble_adjust_carry = lo_fix & ~half_carry_flag; // [RULE_14]
    wire [4:0] hi_base = {1'b0, acc_reg[7:4]} +
                         {4'h0, low_nibble_adjust_carry};
    wire hi_fix = (hi_base > `MIS_BCD_LIMIT) || carry_flag; // [RULE_15]
    wire [4:0] hi_sum = hi_base + `MIS_BCD_ADD;
    wire [3:0] hi_res = hi_fix ? hi_sum[3:0] : hi_base[3:0];

    // result and write-enable decode
    reg [7:0] res;
    reg to_acc;
    reg to_mem;
    reg upd_z;
    reg upd_arith;
    reg extra_cycle;

    // one shared adder serves all four add forms; the carry-in is gated
    // so that the plain adds never pick up a stale carry
    always @* begin
        res = `MIS_ZERO_BYTE;
        to_acc = 1'b0;
        to_mem = 1'b0;
        upd_z = 1'b0;
        upd_arith = 1'b0;
        case (op)
            `MIS_OP_ADC_A, `MIS_OP_ADD_A: begin
                res = sum9[7:0];
                to_acc = 1'b1;
                upd_arith = 1'b1; // [RULE_01] [RULE_02]
            end
            `MIS_OP_ADC_M, `MIS_OP_ADD_M: begin
                res = sum9[7:0];
                to_mem = 1'b1;
                upd_arith = 1'b1; // [RULE_01] [RULE_03]
            end
            `MIS_OP_AND_A: begin
                res = acc_reg & opnd;
                to_acc = 1'b1;
                upd_z = 1'b1; // [RULE_04]
            end
            `MIS_OP_AND_M: begin
                res = acc_reg & mem_rdata;
                to_mem = 1'b1;
                upd_z = 1'b1; // [RULE_05]
            end
            `MIS_OP_CLR_M: begin
                res = `MIS_ZERO_BYTE;
                to_mem = 1'b1; // [RULE_07]
            end
            `MIS_OP_CLR_BIT: begin
                res = mem_rdata & ~(8'h01 << bit_sel);
                to_mem = 1'b1; // [RULE_08]
            end
            `MIS_OP_CPL_M: begin
                res = ~mem_rdata;
                to_mem = 1'b1;
                upd_z = 1'b1; // [RULE_12]
            end
            `MIS_OP_CPL_A: begin
                res = ~mem_rdata;
                to_acc = 1'b1;
                upd_z = 1'b1; // [RULE_13]
            end
            `MIS_OP_DAA: begin
                res = {hi_res, lo_res};
                to_mem = 1'b1; // [RULE_16]
            end
            `MIS_OP_DEC_M, `MIS_OP_DEC_A: begin
                res = mem_rdata - 8'h01;
                to_mem = (op == `MIS_OP_DEC_M);
                to_acc = (op == `MIS_OP_DEC_A);
                upd_z = 1'b1; // [RULE_17]
            end
            `MIS_OP_INC_M, `MIS_OP_INC_A: begin
                res = mem_rdata + 8'h01;
                to_mem = (op == `MIS_OP_INC_M);
                to_acc = (op == `MIS_OP_INC_A);
                upd_z = 1'b1; // [RULE_18]
            end
            default: begin
                res = `MIS_ZERO_BYTE;
            end
        endcase
    end

    // ----------------------------------------
    // instruction cycle pacing
    // ----------------------------------------
    // every op but halt takes one instruction cycle of four clocks; branches take
    // two, and a write to the pc low byte adds one more
    wire go = op_valid && (state_reg == ST_IDLE);
    assign op_ready = (state_reg == ST_IDLE);
    wire is_branch = (op == `MIS_OP_CALL) || (op == `MIS_OP_JMP);

    always @* begin
        extra_cycle = to_mem && mem_is_pc_low_byte; // [RULE_22]
        wait_next = {1'b0, `MIS_CLKS_PER_CYCLE} - 4'd1;
        if (is_branch)
            wait_next = wait_next + {1'b0, `MIS_CLKS_PER_CYCLE};
        if (extra_cycle)
            wait_next = wait_next + {1'b0, `MIS_CLKS_PER_CYCLE}; // [RULE_22]
    end

    // ready stays low for the whole busy count, so the caller never
    // needs to know how long an op takes
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            wait_reg <= 4'd0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (go && op == `MIS_OP_HALT)
                        state_reg <= ST_HALT; // [RULE_19]
                    else if (go) begin
                        state_reg <= ST_BUSY;
                        wait_reg <= wait_next;
                    end
                end
                ST_BUSY: begin
                    if (wait_reg <= 4'd1)
                        state_reg <= ST_IDLE;
                    else
                        wait_reg <= wait_reg - 4'd1;
                end
                ST_HALT: begin
                    state_reg <= ST_HALT; // only reset leaves halt
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // accumulator, memory write, status flags
    // adjust may only raise carry; every other flag keeps its value
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            acc_reg <= `MIS_ZERO_BYTE;
            mem_we <= 1'b0;
            mem_wdata <= `MIS_ZERO_BYTE;
            carry_flag <= `MIS_FLAG_RST;
            half_carry_flag <= `MIS_FLAG_RST;
            zero_flag <= `MIS_FLAG_RST;
            signed_wrap_flag <= `MIS_FLAG_RST;
        end else begin
            mem_we <= go && to_mem;
            if (go && to_mem)
                mem_wdata <= res;
            if (go && to_acc)
                acc_reg <= res;
            if (go && (upd_z || upd_arith))
                zero_flag <= (res == `MIS_ZERO_BYTE); // [RULE_24]
            if (go && upd_arith) begin
                carry_flag <= sum9[8];
                half_carry_flag <= low5[4]; // [RULE_23]
                signed_wrap_flag <= ovf; // [RULE_23]
            end
            if (go && op == `MIS_OP_DAA && hi_fix)
                carry_flag <= 1'b1; // [RULE_15]
        end
    end

    // ----------------------------------------
    // program counter and return stack
    // ----------------------------------------
    wire [PC_W-1:0] pc_plus1 = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
    wire push = go && (op == `MIS_OP_CALL); // [RULE_06]
    // halt still steps the pc

    always @(posedge clk) begin
        if (srst) begin
            pc_reg <= {PC_W{1'b0}};
        end else if (go) begin
            if (is_branch)
                pc_reg <= target_addr; // [RULE_06] [RULE_21]
            else if (op != `MIS_OP_NONE)
                pc_reg <= pc_plus1; // [RULE_19]
        end
    end

    // only the newest entries are kept; a call beyond the depth drops
    // the oldest return address, which software must avoid
    mis_stack #(
        .DEPTH(STACK_DEPTH),
        .AW(PC_W),
        .PW(3)
    ) u_stack (
        .clk(clk),
        .srst(srst),
        .push(push),
        .push_data(pc_plus1),
        .top_data(stack_top),
        .level(stack_level)
    );

    // ----------------------------------------
    // watchdog, prescaler and power flags
    // ----------------------------------------
    // a preclear completes the pair only if the other one is recorded;
    // repeating the same preclear never clears the watchdog
    wire pre_pair = go && ((op == `MIS_OP_PRE1 && preclear_second_seen) ||
                           (op == `MIS_OP_PRE2 && preclear_first_seen));
    wire wdt_clear = (go && op == `MIS_OP_WDT_CLR) || pre_pair;
    // the counter only moves when the prescaler rolls over; halt freezes
    // both, since the clock they count is stopped then
    wire wdt_run = wdt_tick && !halted;
    wire pre_wrap = wdt_run && (&wdt_prescaler);
    wire cnt_wrap = pre_wrap && (&watchdog_counter);

    always @(posedge clk) begin
        if (srst) begin
            watchdog_counter <= {WDT_W{1'b0}};
            wdt_prescaler <= {PRE_W{1'b0}};
            powerdown_flag <= `MIS_FLAG_RST;
            timeout_flag <= `MIS_FLAG_RST;
            preclear_first_seen <= 1'b0;
            preclear_second_seen <= 1'b0;
            halted <= 1'b0;
        end else if (go && op == `MIS_OP_HALT) begin
            watchdog_counter <= {WDT_W{1'b0}};
            wdt_prescaler <= {PRE_W{1'b0}}; // [RULE_20]
            powerdown_flag <= 1'b1;
            timeout_flag <= 1'b0; // [RULE_20]
            halted <= 1'b1; // [RULE_19]
        end else if (wdt_clear) begin
            watchdog_counter <= {WDT_W{1'b0}}; // [RULE_09] [RULE_10]
            wdt_prescaler <= {PRE_W{1'b0}};
            powerdown_flag <= 1'b0;
            timeout_flag <= 1'b0;
            preclear_first_seen <= 1'b0;
            preclear_second_seen <= 1'b0;
        end else begin
            // lone preclear only records itself, counter keeps running
            if (go && op == `MIS_OP_PRE1)
                preclear_first_seen <= 1'b1; // [RULE_11]
            if (go && op == `MIS_OP_PRE2)
                preclear_second_seen <= 1'b1; // [RULE_11]
            if (wdt_run)
                wdt_prescaler <= wdt_prescaler + 1'b1;
            if (pre_wrap)
                watchdog_counter <= watchdog_counter + 1'b1;
            if (cnt_wrap)
                timeout_flag <= 1'b1; // sticky until cleared
        end
    end
endmodule // mis_core

// ===== hw/mis_defines.vh
// shared constants for the instruction semantics unit
`ifndef MIS_DEFINES_VH
`define MIS_DEFINES_VH

// ----------------------------------------
// operation codes on the op port
// ----------------------------------------
`define MIS_OP_NONE 5'h00
`define MIS_OP_ADC_A 5'h01
`define MIS_OP_ADC_M 5'h02
`define MIS_OP_ADD_A 5'h03
`define MIS_OP_ADD_M 5'h04
`define MIS_OP_AND_A 5'h05
`define MIS_OP_AND_M 5'h06
`define MIS_OP_CALL 5'h07
`define MIS_OP_CLR_M 5'h08
`define MIS_OP_CLR_BIT 5'h09
`define MIS_OP_WDT_CLR 5'h0A
`define MIS_OP_PRE1 5'h0B
`define MIS_OP_PRE2 5'h0C
`define MIS_OP_CPL_M 5'h0D
`define MIS_OP_CPL_A 5'h0E
`define MIS_OP_DAA 5'h0F
`define MIS_OP_DEC_M 5'h10
`define MIS_OP_DEC_A 5'h11
`define MIS_OP_INC_M 5'h12
`define MIS_OP_INC_A 5'h13
`define MIS_OP_HALT 5'h14
`define MIS_OP_JMP 5'h15

// ----------------------------------------
// timing, reset and decimal adjust values
// ----------------------------------------
`define MIS_CLKS_PER_CYCLE 3'd4
`define MIS_FLAG_RST 1'b0
`define MIS_BCD_LIMIT 5'd9
`define MIS_BCD_ADD 5'd6
`define MIS_ZERO_BYTE 8'h00

`endif

// ===== hw/mis_stack.v
// return address stack with registered top output
module mis_stack #(
    parameter DEPTH = 6,
    parameter AW = 11,
    parameter PW = 3
) (
    input wire clk,
    input wire srst,
    input wire push,
    input wire [AW-1:0] push_data,
    output reg [AW-1:0] top_data,
    output reg [PW-1:0] level
);
    reg [AW-1:0] mem [0:DEPTH-1];
    reg [PW-1:0] wr_ptr_reg;

    // --------------------------------
    // circular push; the oldest entry is overwritten when full
    // --------------------------------
    always @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= {PW{1'b0}};
            level <= {PW{1'b0}};
            top_data <= {AW{1'b0}};
        end else if (push) begin
            mem[wr_ptr_reg] <= push_data;
            top_data <= push_data;
            if (wr_ptr_reg == DEPTH - 1)
                wr_ptr_reg <= {PW{1'b0}};
            else
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (level != DEPTH)
                level <= level + 1'b1;
        end
    end
endmodule // mis_stack

// ===== sim/mis_core_props.sv
// assertion checker bound to the instruction semantics unit
`include "mis_defines.vh"
module mis_core_props #(
    parameter PC_W = 11,
    parameter STACK_DEPTH = 6,
    parameter WDT_W = 8,
    parameter PRE_W = 8
) (
    input wire clk,
    input wire srst,
    input wire op_valid,
    input wire [4:0] op,
    input wire [7:0] mem_rdata,
    input wire [2:0] bit_sel,
    input wire [PC_W-1:0] target_addr,
    input wire mem_is_pc_low_byte,
    input wire op_ready,
    input wire mem_we,
    input wire [7:0] mem_wdata,
    input wire [7:0] acc_reg,
    input wire [PC_W-1:0] pc_reg,
    input wire carry_flag,
    input wire half_carry_flag,
    input wire zero_flag,
    input wire signed_wrap_flag,
    input wire powerdown_flag,
    input wire timeout_flag,
    input wire halted,
    input wire [WDT_W-1:0] watchdog_counter,
    input wire [PRE_W-1:0] wdt_prescaler,
    input wire [PC_W-1:0] stack_top,
    input wire [2:0] stack_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // a take is an offered op while idle; branches and halt time differently
    wire take = op_valid && op_ready;
    wire [3:0] flg = {carry_flag, half_carry_flag, zero_flag,
        signed_wrap_flag};
    wire br = op == `MIS_OP_CALL || op == `MIS_OP_JMP;
    wire plain = op != `MIS_OP_HALT && op != `MIS_OP_NONE && !br;
    sequence s_short; !op_ready [*3] ##1 op_ready; endsequence
    sequence s_long; !op_ready [*7] ##1 op_ready; endsequence
    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_BUSY_SHORT: assert property (
        take && plain && !mem_is_pc_low_byte |=> s_short)
        else $error("short busy wrong");
    AST_BUSY_PCL: assert property (
        take && op == `MIS_OP_INC_M && mem_is_pc_low_byte |=> s_long)
        else $error("extra cycle missing");
    AST_BRANCH_BUSY: assert property (
        take && br |=> s_long) else $error("branch busy wrong");
    AST_CALL_PUSH: assert property (
        take && op == `MIS_OP_CALL |=> pc_reg == $past(target_addr)
        && stack_top == $past(pc_reg) + 1'b1 && $stable(flg))
        else $error("call wrong");
    AST_JMP_NOPUSH: assert property (
        take && op == `MIS_OP_JMP |=> pc_reg == $past(target_addr)
        && $stable(stack_level) && $stable(flg)) else $error("jump wrong");
    AST_CLR_ZERO: assert property (
        take && op == `MIS_OP_CLR_M |=> mem_we && mem_wdata == 8'h00
        && $stable(flg)) else $error("clear wrong");
    AST_BIT_CLR: assert property (
        take && op == `MIS_OP_CLR_BIT |=> mem_we && $stable(flg) &&
        mem_wdata == ($past(mem_rdata) & ~(8'h01 << $past(bit_sel))))
        else $error("bit clear wrong");
    AST_WDT_CLR: assert property (
        take && op == `MIS_OP_WDT_CLR |=> watchdog_counter == 0
        && !powerdown_flag && !timeout_flag && $stable(flg))
        else $error("watchdog clear wrong");
    AST_HALT: assert property (
        take && op == `MIS_OP_HALT |=> halted && powerdown_flag
        && !timeout_flag && watchdog_counter == 0 && wdt_prescaler == 0
        && pc_reg == $past(pc_reg) + 1'b1) else $error("halt wrong");
    AST_HALT_HOLD: assert property (
        halted |-> !op_ready) else $error("halted yet ready");
    AST_INVERT_TO_ACCUMULATOR: assert property (
        take && op == `MIS_OP_CPL_A |=> !mem_we
        && acc_reg == ~$past(mem_rdata)) else $error("invert_to_accumulator wrong");
    AST_DEC_A: assert property (
        take && op == `MIS_OP_DEC_A |=> !mem_we
        && acc_reg == $past(mem_rdata) - 8'h01
        && zero_flag == (acc_reg == 8'h00)) else $error("minus_one_to_accumulator wrong");
endmodule // mis_core_props

bind mis_core mis_core_props #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH),
    .WDT_W(WDT_W), .PRE_W(PRE_W)) u_props (.clk, .srst, .op_valid, .op,
    .mem_rdata, .bit_sel, .target_addr, .mem_is_pc_low_byte, .op_ready,
    .mem_we, .mem_wdata, .acc_reg, .pc_reg, .carry_flag, .half_carry_flag,
    .zero_flag, .signed_wrap_flag, .powerdown_flag, .timeout_flag, .halted,
    .watchdog_counter, .wdt_prescaler, .stack_top, .stack_level);

// ===== sim/test_mis_core.sv
// random and directed bench for the instruction semantics unit
`include "mis_defines.vh"
module test_mis_core;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk, srst, op_valid, use_imm, mem_is_pc_low_byte, wdt_tick;
    reg [4:0] op, o;
    reg [7:0] mem_rdata, imm_data, e_acc, r, s;
    reg [2:0] bit_sel;
    reg [10:0] target_addr, e_pc, e_t;
    reg e_c, e_h, e_z, e_v, ci;
    wire op_ready, mem_we, carry_flag, half_carry_flag, zero_flag;
    wire signed_wrap_flag, powerdown_flag, timeout_flag, halted;
    wire preclear_first_seen, preclear_second_seen;
    wire [7:0] mem_wdata, acc_reg, watchdog_counter, wdt_prescaler;
    wire [10:0] pc_reg, stack_top;
    wire [2:0] stack_level;
    integer n_fail, checked, seed, i;

    mis_core u_dut (.clk, .srst, .op_valid, .op, .mem_rdata, .imm_data,
        .use_imm, .bit_sel, .target_addr, .mem_is_pc_low_byte, .wdt_tick,
        .op_ready, .mem_we, .mem_wdata, .acc_reg, .pc_reg, .carry_flag,
        .half_carry_flag, .zero_flag, .signed_wrap_flag, .powerdown_flag,
        .timeout_flag, .preclear_first_seen, .preclear_second_seen,
        .halted, .watchdog_counter, .wdt_prescaler, .stack_top,
        .stack_level);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // 8 ns clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d fails %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask

    // returns carry, half carry, signed wrap and the sum
    function [10:0] add_fn(input [7:0] a, b, input cin);
        reg [8:0] t;
        begin
            t = a + b + cin;
            add_fn = {t[8], (a[3:0] + b[3:0] + cin) > 15,
                (a[7] == b[7]) && (t[7] != b[7]), t[7:0]};
        end
    endfunction

    // bcd fix of the accumulator; returns carry and adjusted byte
    function [8:0] daa_fn(input [7:0] a, input h, cy);
        reg [4:0] lo, hi;
        reg k, c2;
        begin
            lo = a[3:0];
            k = 1'b0;
            c2 = cy;
            if (lo > 9 || h) begin
                lo = lo + 5'd6;
                k = !h;
            end
            hi = a[7:4] + k;
            if (hi > 9 || cy) begin
                hi = hi + 5'd6;
                c2 = 1'b1;
            end
            daa_fn = {c2, hi[3:0], lo[3:0]};
        end
    endfunction

    // waits for idle, offers one op, returns when its results show
    task run(input [4:0] c, input [7:0] m, x, input u, input [2:0] b,
        input p);
        integer k;
        begin
            k = 0;
            while (op_ready !== 1'b1 && k < 20) begin
                @(negedge clk);
                k = k + 1;
            end
            if (k == 20) begin
                chk(op_ready, 1'b1);
                end_sim;
            end
            @(posedge clk);
            op_valid <= 1'b1;
            op <= c;
            mem_rdata <= m;
            imm_data <= x;
            use_imm <= u;
            bit_sel <= b;
            mem_is_pc_low_byte <= p;
            target_addr <= e_t;
            @(posedge clk);
            op_valid <= 1'b0;
            @(negedge clk);
        end
    endtask

    // one data op with its expected outcome; the model is the reference
    task alu(input [4:0] c, input [7:0] m, x, input u, input [2:0] b,
        input p);
        reg a_dst;
        begin
            run(c, m, x, u, b, p);
            s = ((c == `MIS_OP_ADD_A || c == `MIS_OP_AND_A) && u) ? x : m;
            ci = (c == `MIS_OP_ADC_A || c == `MIS_OP_ADC_M) && e_c;
            a_dst = c inside {`MIS_OP_ADC_A, `MIS_OP_ADD_A, `MIS_OP_AND_A,
                `MIS_OP_CPL_A, `MIS_OP_DEC_A, `MIS_OP_INC_A};
            e_pc = e_pc + 11'd1;
            case (c)
            `MIS_OP_ADC_A, `MIS_OP_ADC_M, `MIS_OP_ADD_A, `MIS_OP_ADD_M:
                {e_c, e_h, e_v, r} = add_fn(e_acc, s, ci);
            `MIS_OP_AND_A, `MIS_OP_AND_M: r = e_acc & s;
            `MIS_OP_CPL_A, `MIS_OP_CPL_M: r = ~m;
            `MIS_OP_DEC_A, `MIS_OP_DEC_M: r = m - 8'h01;
            `MIS_OP_INC_A, `MIS_OP_INC_M: r = m + 8'h01;
            `MIS_OP_CLR_M: r = 8'h00;
            `MIS_OP_CLR_BIT: r = m & ~(8'h01 << b);
            default: {e_c, r} = daa_fn(e_acc, e_h, e_c);
            endcase
            if (!(c inside {`MIS_OP_CLR_M, `MIS_OP_CLR_BIT, `MIS_OP_DAA}))
                e_z = r == 8'h00;
            if (a_dst)
                e_acc = r;
            chk(acc_reg, e_acc);
            chk({carry_flag, half_carry_flag}, {e_c, e_h});
            chk({zero_flag, signed_wrap_flag}, {e_z, e_v});
            chk(mem_we, !a_dst);
            if (!a_dst)
                chk(mem_wdata, r);
            chk(pc_reg, e_pc);
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {n_fail, checked, i} = 0;
        seed = 32'h14bb;
        srst = 1'b1;
        {op_valid, op, mem_rdata, imm_data, use_imm} = 0;
        {bit_sel, target_addr, mem_is_pc_low_byte, wdt_tick} = 0;
        {e_acc, e_pc, e_t, e_c, e_h, e_z, e_v} = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        // overflow, half carry, wrap to zero, bcd fix, pc low byte write
        alu(`MIS_OP_ADD_A, 8'h00, 8'h7F, 1'b1, 3'd0, 1'b0);
        alu(`MIS_OP_ADD_A, 8'h01, 8'h00, 1'b0, 3'd0, 1'b0);
        alu(`MIS_OP_ADD_M, 8'h80, 8'h00, 1'b0, 3'd0, 1'b0);
        alu(`MIS_OP_ADC_A, 8'hFF, 8'h00, 1'b0, 3'd0, 1'b0);
        alu(`MIS_OP_DAA, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
        alu(`MIS_OP_INC_M, 8'hFF, 8'h00, 1'b0, 3'd0, 1'b1);
        alu(`MIS_OP_CLR_BIT, 8'hFF, 8'h00, 1'b0, 3'd7, 1'b0);
        $display("corner ops done");
        for (i = 0; i < 300; i = i + 1) begin
            o = 5'h01 + $unsigned($random(seed)) % 19;
            if (o inside {`MIS_OP_CALL, `MIS_OP_WDT_CLR, `MIS_OP_PRE1,
                `MIS_OP_PRE2})
                o = `MIS_OP_DAA;
            alu(o, $random(seed), $random(seed), $random(seed),
                $random(seed), ($random(seed) & 7) == 0);
        end
        $display("random ops done");
        // 600 ticks give two prescaler wraps before the preclear pair
        @(posedge clk);
        wdt_tick <= 1'b1;
        repeat (600) @(posedge clk);
        wdt_tick <= 1'b0;
        run(`MIS_OP_PRE1, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
        chk(watchdog_counter, 8'h02);
        chk(preclear_first_seen, 1'b1);
        chk(preclear_second_seen, 1'b0);
        chk(wdt_prescaler, 8'h58);
        run(`MIS_OP_PRE2, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
        chk(watchdog_counter, 8'h00);
        chk({preclear_first_seen, preclear_second_seen}, 2'b00);
        // a full counter wrap raises time-out; a lone preclear keeps it
        @(posedge clk);
        wdt_tick <= 1'b1;
        repeat (65536) @(posedge clk);
        wdt_tick <= 1'b0;
        run(`MIS_OP_PRE2, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
        chk({timeout_flag, preclear_second_seen}, 2'b11);
        run(`MIS_OP_WDT_CLR, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
        chk({powerdown_flag, timeout_flag}, 2'b00);
        chk(watchdog_counter, 8'h00);
        e_pc = e_pc + 11'd4;
        $display("watchdog done");
        // seven calls push past the six-deep stack
        for (i = 1; i < 8; i = i + 1) begin
            e_t = $random(seed);
            run(`MIS_OP_CALL, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
            chk(stack_top, 11'(e_pc + 11'd1));
            chk(stack_level, (i > 6) ? 6 : i);
            chk(pc_reg, e_t);
            e_pc = e_t;
        end
        e_t = 11'h7FF;
        run(`MIS_OP_JMP, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
        chk(pc_reg, e_t);
        chk(stack_level, 3'd6);
        run(`MIS_OP_HALT, 8'h00, 8'h00, 1'b0, 3'd0, 1'b0);
        chk(pc_reg, 11'(e_t + 11'd1));
        chk({halted, powerdown_flag, timeout_flag}, 3'b110);
        repeat (10) @(negedge clk);
        chk(op_ready, 1'b0);
        chk(acc_reg, e_acc);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(op_ready, 1'b1);
        $display("branch and halt done");
        end_sim;
    end
endmodule // test_mis_core
